// >>> design/rmul_pkg.sv
// Constants and carrier types for the registered 12x12 multiplier
package rmul_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int unsigned RMUL_OPW = 12;
  localparam int unsigned RMUL_PW = 24;
  localparam int unsigned RMUL_AW = 8;
  localparam int unsigned RMUL_DW = 32;

  // ----------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] RMUL_ADDR_OPA = 8'h00;
  localparam logic [7:0] RMUL_ADDR_OPB = 8'h04;
  localparam logic [7:0] RMUL_ADDR_CTRL = 8'h08;
  localparam logic [7:0] RMUL_ADDR_LOAD = 8'h0C;
  localparam logic [7:0] RMUL_ADDR_RESULT = 8'h10;
  localparam logic [7:0] RMUL_ADDR_PRODUCT = 8'h14;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned RMUL_OP_SIGNED_BIT = 12;
  localparam int unsigned RMUL_CTRL_W = 5;
  localparam int unsigned RMUL_CTRL_ROUNDQ_BIT = 5;
  localparam int unsigned RMUL_LOAD_UPPER_BIT = 0;
  localparam int unsigned RMUL_LOAD_LOWER_BIT = 1;

  // Round constants: one at the top bit of the lower half as presented
  localparam logic [23:0] RMUL_RND_FULL = 24'h000800;
  localparam logic [23:0] RMUL_RND_SHIFT = 24'h000400;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    RMUL_REG_OPA = 3'h0,
    RMUL_REG_OPB = 3'h1,
    RMUL_REG_CTRL = 3'h2,
    RMUL_REG_LOAD = 3'h3,
    RMUL_REG_RESULT = 3'h4,
    RMUL_REG_PRODUCT = 3'h5,
    RMUL_REG_NONE = 3'h7
  } rmul_reg_t;

  typedef struct packed {
    logic signed_sel;
    logic [11:0] data;
  } rmul_operand_t;

  typedef struct packed {
    logic lower_output_enable_n;
    logic upper_output_enable_n;
    logic result_feedthrough;
    logic output_shift_sel;
    logic round_request;
  } rmul_ctrl_t;

  typedef struct packed {
    logic [11:0] upper;
    logic [11:0] lower;
  } rmul_result_t;

  typedef struct packed {
    rmul_operand_t opa;
    rmul_operand_t opb;
    rmul_ctrl_t ctrl;
    logic round_q;
    rmul_result_t res;
    logic upper_oe;
    logic lower_oe;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } rmul_state_t;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam rmul_ctrl_t RMUL_CTRL_RST = 5'h18;
  localparam rmul_state_t RMUL_STATE_RST = '{
    opa: 13'h0000,
    opb: 13'h0000,
    ctrl: RMUL_CTRL_RST,
    round_q: 1'b0,
    res: 24'h000000,
    upper_oe: 1'b0,
    lower_oe: 1'b0,
    pready: 1'b0,
    pslverr: 1'b0,
    prdata: 32'h00000000
  };

endpackage : rmul_pkg

// >>> design/rmul_core.sv
// Combinational 12x12 product with rounding and output formatting
`timescale 1ns/1ps
module rmul_core (
  input wire rmul_pkg::rmul_operand_t opa, // Registered operand A
  input wire rmul_pkg::rmul_operand_t opb, // Registered operand B
  input wire logic round_q, // Registered round request
  input wire logic shift_sel, // Output shift select
  output rmul_pkg::rmul_result_t result // Formatted halves
);
  import rmul_pkg::*;

  logic signed [12:0] a_ext;
  logic signed [12:0] b_ext;
  logic signed [25:0] prod;
  logic [23:0] rnd_add;
  logic [23:0] rounded;

  // Each operand widened by its own sign rule, so mixed pairs work
  assign a_ext = $signed({opa.signed_sel & opa.data[11], opa.data});
  assign b_ext = $signed({opb.signed_sel & opb.data[11], opb.data});
  assign prod = a_ext * b_ext;

  always_comb begin
    rnd_add = 24'h000000;
    if (round_q) begin
      rnd_add = shift_sel ? RMUL_RND_FULL : RMUL_RND_SHIFT;
    end
    rounded = prod[23:0] + rnd_add;
    if (shift_sel) begin
      result.upper = rounded[23:12];
      result.lower = rounded[11:0];
    end else begin
      // Drops the redundant top bit and repeats the sign in the lower half
      result.upper = rounded[22:11];
      result.lower = {rounded[22], rounded[10:0]};
    end
  end

endmodule : rmul_core

// >>> design/rmul_top.sv
// Registered 12x12 multiplier with APB register access
`timescale 1ns/1ps
module rmul_top (
  input wire logic pclk, // Bus and core clock
  input wire logic presetn, // Asynchronous reset, active low
  input wire logic pclk_en, // Clock enable, freezes all state
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error for unmapped address
  output logic [11:0] upper_result_half, // Upper result pins
  output logic upper_result_oe, // Upper pins driven when high
  output logic [11:0] lower_result_half, // Lower result pins
  output logic lower_result_oe // Lower pins driven when high
);
  import rmul_pkg::*;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  function automatic rmul_reg_t rmul_decode(input logic [7:0] addr);
    rmul_reg_t r;
    case (addr)
      RMUL_ADDR_OPA: r = RMUL_REG_OPA;
      RMUL_ADDR_OPB: r = RMUL_REG_OPB;
      RMUL_ADDR_CTRL: r = RMUL_REG_CTRL;
      RMUL_ADDR_LOAD: r = RMUL_REG_LOAD;
      RMUL_ADDR_RESULT: r = RMUL_REG_RESULT;
      RMUL_ADDR_PRODUCT: r = RMUL_REG_PRODUCT;
      default: r = RMUL_REG_NONE;
    endcase
    return r;
  endfunction : rmul_decode

  rmul_state_t s_q;
  rmul_state_t s_d;
  rmul_result_t core_res;
  rmul_reg_t rd_sel;
  rmul_reg_t wr_sel;
  logic setup_ph;
  logic wr_fire;
  logic wr_opa;
  logic wr_opb;
  logic ld_upper;
  logic ld_lower;

  // ----------------------------------------------------------------
  // Product datapath
  // ----------------------------------------------------------------
  rmul_core u_core (
    .opa(s_q.opa),
    .opb(s_q.opb),
    .round_q(s_q.round_q),
    .shift_sel(s_q.ctrl.output_shift_sel),
    .result(core_res)
  );

  // ----------------------------------------------------------------
  // Bus phases
  // ----------------------------------------------------------------
  // Read data is sampled in the setup cycle so prdata can leave a flop;
  // a result moving in feedthrough mode is therefore one cycle old.
  assign setup_ph = psel & ~penable;
  assign wr_fire = psel & penable & pwrite & s_q.pready;
  assign rd_sel = rmul_decode(paddr);
  assign wr_sel = wr_fire ? rmul_decode(paddr) : RMUL_REG_NONE;
  // Writing an operand register stands in for that operand's clock edge
  assign wr_opa = (wr_sel == RMUL_REG_OPA);
  assign wr_opb = (wr_sel == RMUL_REG_OPB);
  assign ld_upper = (wr_sel == RMUL_REG_LOAD) &
                    pwdata[RMUL_LOAD_UPPER_BIT];
  assign ld_lower = (wr_sel == RMUL_REG_LOAD) &
                    pwdata[RMUL_LOAD_LOWER_BIT];

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.pready = setup_ph;
    if (setup_ph) begin
      s_d.pslverr = (rd_sel == RMUL_REG_NONE);
      s_d.prdata = 32'h00000000;
      case (rd_sel)
        RMUL_REG_OPA: s_d.prdata = {19'h00000, s_q.opa};
        RMUL_REG_OPB: s_d.prdata = {19'h00000, s_q.opb};
        RMUL_REG_CTRL: s_d.prdata = {26'h0000000, s_q.round_q, s_q.ctrl};
        RMUL_REG_RESULT: s_d.prdata = {8'h00, s_q.res};
        RMUL_REG_PRODUCT: s_d.prdata = {8'h00, core_res};
        default: s_d.prdata = 32'h00000000;
      endcase
    end
    if (wr_opa) begin
      s_d.opa = pwdata[RMUL_OP_SIGNED_BIT:0];
    end
    if (wr_opb) begin
      s_d.opb = pwdata[RMUL_OP_SIGNED_BIT:0];
    end
    // Round request samples on either operand load, like an OR of clocks
    if (wr_opa | wr_opb) begin
      s_d.round_q = s_q.ctrl.round_request;
    end
    if (wr_sel == RMUL_REG_CTRL) begin
      s_d.ctrl = pwdata[RMUL_CTRL_W-1:0];
    end
    if (ld_upper | s_q.ctrl.result_feedthrough) begin
      s_d.res.upper = core_res.upper;
    end
    if (ld_lower | s_q.ctrl.result_feedthrough) begin
      s_d.res.lower = core_res.lower;
    end
    // Each half drives its pins only while its own enable is low
    s_d.upper_oe = ~s_q.ctrl.upper_output_enable_n;
    s_d.lower_oe = ~s_q.ctrl.lower_output_enable_n;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= RMUL_STATE_RST;
    end else if (pclk_en) begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign prdata = s_q.prdata;
  assign pready = s_q.pready;
  assign pslverr = s_q.pslverr;
  // Pins carry the register always; the enable decides who owns the wire
  assign upper_result_half = s_q.res.upper;
  assign upper_result_oe = s_q.upper_oe;
  assign lower_result_half = s_q.res.lower;
  assign lower_result_oe = s_q.lower_oe;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic signed [12:0] chk_a;
  logic signed [12:0] chk_b;
  logic signed [25:0] chk_prod;
  logic [23:0] chk_full;
  logic [23:0] chk_half;
  logic upd;

  assign chk_a = $signed({s_q.opa.signed_sel & s_q.opa.data[11],
                          s_q.opa.data});
  assign chk_b = $signed({s_q.opb.signed_sel & s_q.opb.data[11],
                          s_q.opb.data});
  assign chk_prod = chk_a * chk_b;
  assign chk_full = chk_prod[23:0] + (s_q.round_q ? RMUL_RND_FULL :
                                      24'h000000);
  assign chk_half = chk_prod[23:0] + (s_q.round_q ? RMUL_RND_SHIFT :
                                      24'h000000);
  assign upd = presetn & pclk_en;

  a_opa_capture:
    assert property (@(posedge pclk) disable iff (!presetn)
      (upd && wr_opa) |=> s_q.opa == $past(pwdata[12:0]))
    else $error("operand A not captured on write");

  a_opb_capture:
    assert property (@(posedge pclk) disable iff (!presetn)
      (upd && wr_opb) |=> s_q.opb == $past(pwdata[12:0]))
    else $error("operand B not captured on write");

  a_round_capture:
    assert property (@(posedge pclk) disable iff (!presetn)
      (upd && (wr_opa || wr_opb))
        |=> s_q.round_q == $past(s_q.ctrl.round_request))
    else $error("round request not taken on operand load");

  a_round_hold:
    assert property (@(posedge pclk) disable iff (!presetn)
      !(upd && (wr_opa || wr_opb)) |=> $stable(s_q.round_q))
    else $error("round request changed without operand load");

  a_full_product:
    assert property (@(posedge pclk) disable iff (!presetn)
      s_q.ctrl.output_shift_sel |-> core_res == chk_full)
    else $error("full product or rounding wrong");

  a_sign_copy:
    assert property (@(posedge pclk) disable iff (!presetn)
      !s_q.ctrl.output_shift_sel |->
        core_res.lower[11] == core_res.upper[11] &&
        core_res.upper == chk_half[22:11] &&
        core_res.lower[10:0] == chk_half[10:0])
    else $error("shifted format or sign copy wrong");

  a_upper_load:
    assert property (@(posedge pclk) disable iff (!presetn)
      (upd && ld_upper) |=> s_q.res.upper == $past(core_res.upper))
    else $error("upper half not loaded");

  a_lower_hold:
    assert property (@(posedge pclk) disable iff (!presetn)
      (!ld_lower && !s_q.ctrl.result_feedthrough) |=>
        $stable(s_q.res.lower))
    else $error("lower half moved without load");

  a_feed_follow:
    assert property (@(posedge pclk) disable iff (!presetn)
      (upd && s_q.ctrl.result_feedthrough) ##1 pclk_en |->
        lower_result_half == $past(core_res.lower) &&
        upper_result_half == $past(core_res.upper))
    else $error("feedthrough result not followed");

  a_enable_pins:
    assert property (@(posedge pclk) disable iff (!presetn)
      upd |=> upper_result_oe == !$past(s_q.ctrl.upper_output_enable_n) &&
        lower_result_oe == !$past(s_q.ctrl.lower_output_enable_n))
    else $error("output enable does not follow control");

  a_apb_ready:
    assert property (@(posedge pclk) disable iff (!presetn)
      (upd && setup_ph) |=> pready ##1 (!pready || !pclk_en))
    else $error("ready not a single cycle after setup");

  // ----------------------------------------------------------------
  // Datapath and bus checks
  // ----------------------------------------------------------------
  // Sign rules, except unsigned A with signed B, are checked through two's
  // complement identities rather than the widened multiply, so a wrong extension cannot hide there

  a_upper_hold:
    assert property (@(posedge pclk) disable iff (!presetn)
      (!ld_upper && !s_q.ctrl.result_feedthrough) |=>
        $stable(s_q.res.upper))
    else $error("upper half moved without load");

  a_lower_load:
    assert property (@(posedge pclk) disable iff (!presetn)
      (upd && ld_lower) |=> s_q.res.lower == $past(core_res.lower))
    else $error("lower half not loaded");

  a_opa_hold:
    assert property (@(posedge pclk) disable iff (!presetn)
      !(upd && wr_opa) |=> $stable(s_q.opa))
    else $error("operand A changed without write");

  a_opb_hold:
    assert property (@(posedge pclk) disable iff (!presetn)
      !(upd && wr_opb) |=> $stable(s_q.opb))
    else $error("operand B changed without write");

  a_unsigned_prod:
    assert property (@(posedge pclk) disable iff (!presetn)
      (!s_q.opa.signed_sel && !s_q.opb.signed_sel &&
       s_q.ctrl.output_shift_sel && !s_q.round_q) |->
        core_res == 24'(s_q.opa.data) * 24'(s_q.opb.data))
    else $error("unsigned product wrong");

  a_mixed_prod:
    assert property (@(posedge pclk) disable iff (!presetn)
      (s_q.opa.signed_sel && !s_q.opb.signed_sel &&
       s_q.ctrl.output_shift_sel && !s_q.round_q) |->
        core_res == 24'(s_q.opa.data) * 24'(s_q.opb.data) -
          (s_q.opa.data[11] ? {s_q.opb.data, 12'h000} : 24'h000000))
    else $error("mixed sign product wrong");

  a_signed_prod:
    assert property (@(posedge pclk) disable iff (!presetn)
      (s_q.opa.signed_sel && s_q.opb.signed_sel &&
       s_q.ctrl.output_shift_sel && !s_q.round_q) |->
        core_res == 24'(s_q.opa.data) * 24'(s_q.opb.data) -
          (s_q.opa.data[11] ? {s_q.opb.data, 12'h000} : 24'h000000) -
          (s_q.opb.data[11] ? {s_q.opa.data, 12'h000} : 24'h000000))
    else $error("signed product wrong");

  a_ctrl_write:
    assert property (@(posedge pclk) disable iff (!presetn)
      (upd && wr_sel == RMUL_REG_CTRL) |=> s_q.ctrl == $past(pwdata[4:0]))
    else $error("control word not written");

  a_unmapped_err:
    assert property (@(posedge pclk) disable iff (!presetn)
      (upd && setup_ph && rd_sel == RMUL_REG_NONE) |=>
        pslverr && prdata == 32'h00000000)
    else $error("unmapped access not flagged");

  a_mapped_ok:
    assert property (@(posedge pclk) disable iff (!presetn)
      (upd && setup_ph && rd_sel != RMUL_REG_NONE) |=> !pslverr)
    else $error("error flagged for mapped address");

  a_ready_cause:
    assert property (@(posedge pclk) disable iff (!presetn)
      (upd && !setup_ph) |=> !pready)
    else $error("ready without setup cycle");

  a_read_result:
    assert property (@(posedge pclk) disable iff (!presetn)
      (upd && setup_ph && rd_sel == RMUL_REG_RESULT) |=>
        prdata == {8'h00, $past(s_q.res)})
    else $error("result read does not match registers");

  a_read_ctrl:
    assert property (@(posedge pclk) disable iff (!presetn)
      (upd && setup_ph && rd_sel == RMUL_REG_CTRL) |=>
        prdata == {26'h0000000, $past(s_q.round_q), $past(s_q.ctrl)})
    else $error("control read does not match registers");

  a_write_ignored:
    assert property (@(posedge pclk) disable iff (!presetn)
      (upd && wr_fire && rd_sel == RMUL_REG_NONE) |=>
        $stable(s_q.ctrl) && $stable(s_q.opa) && $stable(s_q.opb) &&
        $stable(s_q.round_q))
    else $error("unmapped write changed state");

  c_mixed_sign:
    cover property (@(posedge pclk) disable iff (!presetn)
      s_q.opa.signed_sel != s_q.opb.signed_sel && ld_upper);

  c_feedthrough:
    cover property (@(posedge pclk) disable iff (!presetn)
      s_q.ctrl.result_feedthrough && upper_result_oe && lower_result_oe);

  c_rounded_shift:
    cover property (@(posedge pclk) disable iff (!presetn)
      s_q.round_q && !s_q.ctrl.output_shift_sel && ld_lower);

  c_unmapped:
    cover property (@(posedge pclk) disable iff (!presetn)
      pready && pslverr);

  c_rounded_full:
    cover property (@(posedge pclk) disable iff (!presetn)
      s_q.round_q && s_q.ctrl.output_shift_sel && ld_upper);

endmodule : rmul_top

// >>> testbench/rmul_pin_bus.sv
// Model of the shared result bus that the three-state halves drive
`timescale 1ns/1ps
module rmul_pin_bus (
  input wire logic pclk, // Core clock
  input wire logic [11:0] upper_result_half, // Upper result pins
  input wire logic upper_result_oe, // Upper pins driven when high
  input wire logic [11:0] lower_result_half, // Lower result pins
  input wire logic lower_result_oe, // Lower pins driven when high
  output logic [11:0] bus_upper, // Resolved upper bus level
  output logic [11:0] bus_lower // Resolved lower bus level
);
  logic [11:0] last_u_q;
  logic [11:0] last_l_q;

  // ----------------------------------------------------------------
  // Released bus
  // ----------------------------------------------------------------
  // No pull-up on the bus: a released half shows the inverse of the
  // last driven value so stale data can never pass for a match
  always_ff @(posedge pclk) begin
    if (upper_result_oe) begin
      last_u_q <= upper_result_half;
    end
    if (lower_result_oe) begin
      last_l_q <= lower_result_half;
    end
  end

  assign bus_upper = upper_result_oe ? upper_result_half : ~last_u_q;
  assign bus_lower = lower_result_oe ? lower_result_half : ~last_l_q;
endmodule : rmul_pin_bus

// >>> testbench/registered_12x12_multiplier_bench.sv
// Self-checking bench for the registered 12x12 multiplier
`timescale 1ns/1ps
module registered_12x12_multiplier_bench;
  import rmul_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, rn;
  logic upper_result_oe, lower_result_oe, sa, sb, r, r2, s;
  logic [11:0] upper_result_half, lower_result_half, bus_upper, bus_lower;
  logic [11:0] a, b;
  logic [23:0] exp_v, res_v;
  int error_cnt, tests_run, seed;

  rmul_top i_dut (.pclk(pclk), .presetn(presetn), .pclk_en(1'b1),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .upper_result_half(upper_result_half),
    .upper_result_oe(upper_result_oe),
    .lower_result_half(lower_result_half),
    .lower_result_oe(lower_result_oe));

  rmul_pin_bus i_bus (.pclk(pclk), .upper_result_half(upper_result_half),
    .upper_result_oe(upper_result_oe), .lower_result_half(lower_result_half),
    .lower_result_oe(lower_result_oe), .bus_upper(bus_upper),
    .bus_lower(bus_lower));

  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  // ----------------------------------------------------------------
  // Tasks and reference
  // ----------------------------------------------------------------
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected %s exp %h got %h", nm, e, g);
    end
  endtask : chk

  // Request held until pready is sampled high at a rising edge
  task automatic apb(input logic wr, input logic [7:0] ad,
                     input logic [31:0] wd);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) begin
      error_cnt++;
      $display("unexpected pready exp 1 got %b", pready);
      report_and_stop();
    end
  endtask : apb

  // Rounding sits at the top bit of the lower half as presented
  function automatic logic [23:0] fmt(logic [11:0] x, logic xs,
    logic [11:0] y, logic ys, logic rq, logic sh);
    logic signed [25:0] p;
    logic [23:0] q;
    p = $signed({xs & x[11], x}) * $signed({ys & y[11], y});
    if (sh) begin
      q = p[23:0] + (rq ? 24'h000800 : 24'h000000);
    end else begin
      q = p[23:0] + (rq ? 24'h000400 : 24'h000000);
      q = {q[22:11], q[22], q[10:0]};
    end
    return q;
  endfunction : fmt

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    seed = 79920;
    error_cnt = 0;
    tests_run = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    res_v = 24'h000000;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, RMUL_ADDR_CTRL, 32'h00000000);
    chk("ctrl reset", 32'h00000018, rd);
    chk("oe reset", 32'h0, {30'h0, upper_result_oe, lower_result_oe});
    $display("test reset done");
    for (int i = 0; i < 40; i++) begin
      rn = $random(seed);
      {a, b, sa, sb, r, r2, s} = rn[28:0];
      if (i < 8) begin
        a = i[2] ? 12'h800 : 12'hFFF;
        b = 12'h800;
        sa = i[0];
        sb = i[1];
      end
      apb(1'b1, RMUL_ADDR_CTRL, {30'h0, s, r});
      apb(1'b1, RMUL_ADDR_OPA, {19'h0, sa, a});
      apb(1'b1, RMUL_ADDR_CTRL, {30'h0, s, r2});
      apb(1'b1, RMUL_ADDR_OPB, {19'h0, sb, b});
      exp_v = fmt(a, sa, b, sb, r2, s);
      apb(1'b0, RMUL_ADDR_CTRL, 32'h0);
      chk("round_q", {26'h0, r2, 3'b000, s, r2}, rd);
      apb(1'b0, RMUL_ADDR_PRODUCT, 32'h0);
      chk("product", {8'h0, exp_v}, rd);
      apb(1'b1, RMUL_ADDR_LOAD, 32'h00000001);
      apb(1'b0, RMUL_ADDR_RESULT, 32'h0);
      chk("upper load", {8'h0, exp_v[23:12], res_v[11:0]}, rd);
      apb(1'b1, RMUL_ADDR_LOAD, 32'h00000002);
      apb(1'b0, RMUL_ADDR_RESULT, 32'h0);
      chk("lower load", {8'h0, exp_v}, rd);
      res_v = exp_v;
      chk("pins", {8'h0, exp_v}, {8'h0, bus_upper, bus_lower});
    end
    $display("test random products done");
    rn = $random(seed);
    a = rn[11:0];
    apb(1'b1, RMUL_ADDR_CTRL, 32'h00000006);
    apb(1'b1, RMUL_ADDR_OPA, {19'h0, 1'b0, a});
    exp_v = fmt(a, 1'b0, b, sb, 1'b0, 1'b1);
    repeat (3) @(posedge pclk);
    chk("feedthrough", {8'h0, exp_v}, {8'h0, bus_upper, bus_lower});
    $display("test feedthrough done");
    apb(1'b1, RMUL_ADDR_CTRL, 32'h00000008);
    repeat (2) @(posedge pclk);
    chk("oe split", 32'h1, {30'h0, upper_result_oe, lower_result_oe});
    chk("released", {20'h0, ~exp_v[23:12]}, {20'h0, bus_upper});
    apb(1'b1, RMUL_ADDR_CTRL, 32'h00000018);
    repeat (2) @(posedge pclk);
    chk("oe off", 32'h0, {30'h0, upper_result_oe, lower_result_oe});
    $display("test enables done");
    apb(1'b0, 8'h18, 32'h0);
    chk("unmapped", 32'h1, {31'h0, err});
    apb(1'b1, 8'h18, 32'h0000001F);
    chk("unmapped write", 32'h1, {31'h0, err});
    apb(1'b0, RMUL_ADDR_CTRL, 32'h0);
    chk("ctrl kept", 32'h00000018, rd);
    $display("test unmapped done");
    report_and_stop();
  end
endmodule : registered_12x12_multiplier_bench
